// ===== design/mmd_core_map.sv
// Core memory-map decode: code source, RAM, SFRs, stack and data space.
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// - Latch code source select after reset release.
// - Internal-mode fetches at F800H and above return NOP.
// - Direct upper addresses select SFRs, indirect RAM.
// - Lowest 32 RAM bytes form four banks.
// - Status word bits 4:3 pick register bank.
// - Bit addresses 00H-7FH map to 20H-2FH.
// - Stack pointer resets 07H, push pre-increments.
// - Map enable routes low 2K to extended RAM.
// - Pointers above 0007FFH always go external.
// - Extended RAM accesses leave pins and strobes idle.
// - Stack wraps at FFH unless extension enabled.
// - Stack pointer low at 81H, high at B7H.
// - External data moves strobe, 24-bit address.
// - Data pointer bytes separate, increment carries page.
// - Status word at D0H, resets 00H.
// - Program flash rewrite handled outside this decode.
// - Data flash registers decode outside; read zero.
// - Configuration register resets to standard mode.
module mmd_core_map #(
  parameter int unsigned STROBE_CYC = mmd_pkg::EXT_STROBE_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              code_source_select_n,
  input  wire logic [7:0]        acc_value,
  input  wire logic              fetch_req,
  input  wire logic [15:0]       fetch_addr,
  input  wire logic              req_valid,
  input  wire mmd_pkg::mmd_kind_t req_kind,
  input  wire logic              req_we,
  input  wire logic [7:0]        req_addr,
  input  wire logic [7:0]        req_wdata,
  input  wire logic              data_pointer_inc,
  input  wire logic [7:0]        port_zero_pins_in,
  output logic                   busy_q,
  output logic                   done_q,
  output logic      [7:0]        rdata_q,
  output logic                   ext_mode_q,
  output logic                   fetch_nop_q,
  output logic                   fetch_ext_q,
  output logic      [7:0]        psw_q,
  output logic      [10:0]       sp_q,
  output logic      [23:0]       data_pointer_q,
  output logic      [23:0]       xaddr_q,
  output logic                   rd_n_q,
  output logic                   wr_n_q,
  output logic      [7:0]        port_zero_pins_out_q,
  output logic                   port_zero_pins_oe_q,
  output logic      [7:0]        port_two_pins_out_q,
  output logic                   port_two_pins_oe_q
);
  import mmd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State and submodules.

  typedef struct packed {
    mmd_state_t  st;        // Access sequencer state.
    logic [1:0]  boot_cnt;  // Cycles since reset release.
    logic        ext_mode;  // Code runs from external space.
    logic [10:0] sp;        // Stack pointer, low byte plus high three bits.
    logic [7:0]  processor_status_word;       // Status word.
    logic [7:0]  cfg;       // Core configuration register.
    logic [7:0]  data_ptr_page;       // Data pointer page byte.
    logic [7:0]  data_ptr_high;       // Data pointer high byte.
    logic [7:0]  data_ptr_low;       // Data pointer low byte.
    mmd_kind_t   kind;      // Latched request kind.
    logic        we;        // Latched write flag.
    logic [2:0]  bitpos;    // Latched bit position.
    logic [7:0]  wdata;     // Latched write data.
    logic [10:0] maddr;     // Resolved RAM address.
    logic        onchip_extended_ram;      // Target is the extended RAM.
    logic [2:0]  cnt;       // External strobe countdown.
    logic [23:0] xaddr;     // External data address.
    logic        rd_n;
    logic        wr_n;
    logic [7:0]  p0_out;
    logic        p0_oe;
    logic [7:0]  p2_out;
    logic        p2_oe;
    logic [7:0]  rdata;
    logic        done;
    logic        busy;
    logic        fetch_nop;
    logic        fetch_ext;
  } mmd_core_st_t;

  localparam mmd_core_st_t S_RESET = '{st: ST_IDLE, sp: SP_RESET, processor_status_word: PSW_RESET,
                                       cfg: CFG_RESET, kind: K_DIRECT, rd_n: 1'b1,
                                       wr_n: 1'b1, default: '0};
  localparam logic [2:0] STROBE_LAST = 3'(STROBE_CYC - 1);

  mmd_core_st_t s_q;
  mmd_core_st_t s_d;
  logic         src_sync;   // Synchronised code source select.
  logic [7:0]   p0_sync;    // Synchronised port zero read data.
  logic [23:0]  data_pointer;       // Current data pointer.
  logic         taken;      // A request is accepted this cycle.
  logic [7:0]   ram_rd;     // Read byte from whichever RAM was targeted.

  mmd_ram_if #(.AW(IRAM_AW)) iram_bus ();
  mmd_ram_if #(.AW(ONCHIP_EXTENDED_RAM_AW)) onchip_extended_ram_bus ();

  mmd_sync #(.W(1)) u_src_sync (.clk(clk), .rst_n(rst_n), .d(code_source_select_n),
                                .q(src_sync));
  mmd_sync #(.W(8)) u_p0_sync (.clk(clk), .rst_n(rst_n), .d(port_zero_pins_in),
                               .q(p0_sync));
  mmd_ram #(.AW(IRAM_AW)) u_iram (.clk(clk), .rst_n(rst_n), .bus(iram_bus.mem));
  mmd_ram #(.AW(ONCHIP_EXTENDED_RAM_AW)) u_onchip_extended_ram (.clk(clk), .rst_n(rst_n), .bus(onchip_extended_ram_bus.mem));

  assign data_pointer   = {s_q.data_ptr_page, s_q.data_ptr_high, s_q.data_ptr_low};
  assign taken  = req_valid && (s_q.st == ST_IDLE);
  assign ram_rd = s_q.onchip_extended_ram ? onchip_extended_ram_bus.rdata : iram_bus.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // RAM port drive. Bit writes read first, then write the merged byte.

  always_comb
  begin
    logic       wr_bit;
    logic       en;
    logic [7:0] merged;
    wr_bit = (s_q.st == ST_WAIT) && (s_q.kind == K_BIT) && s_q.we;
    en     = (s_q.st == ST_ISSUE) || wr_bit;
    merged = ram_rd;
    merged[s_q.bitpos] = s_q.wdata[0];
    iram_bus.en    = en && !s_q.onchip_extended_ram;
    onchip_extended_ram_bus.en    = en && s_q.onchip_extended_ram;
    iram_bus.we    = wr_bit || (s_q.we && (s_q.kind != K_BIT));
    onchip_extended_ram_bus.we    = iram_bus.we;
    iram_bus.addr  = s_q.maddr[IRAM_AW-1:0];
    onchip_extended_ram_bus.addr  = s_q.maddr;
    iram_bus.wdata = wr_bit ? merged : s_q.wdata;
    onchip_extended_ram_bus.wdata = iram_bus.wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb
  begin
    logic [7:0]  sfr_addr;
    logic [7:0]  sfr_old;
    logic [7:0]  sfr_new;
    logic [10:0] sp_n;
    s_d       = s_q;
    s_d.done  = 1'b0;
    sfr_addr  = (req_kind == K_BIT) ? {req_addr[7:3], 3'b000} : req_addr;
    sfr_old   = 8'h00;
    sfr_new   = req_wdata;
    sp_n      = s_q.sp;

    // Parity follows the accumulator every cycle.
    s_d.processor_status_word[PSW_P] = ^acc_value;

    // Code source is caught once the synchroniser has filled after reset.
    if (s_q.boot_cnt != BOOT_SYNC_CYC)
    begin
      s_d.boot_cnt = s_q.boot_cnt + 2'h1;
      s_d.ext_mode = ~src_sync;
    end

    // Internal code never rolls into the top region; it reads as NOP.
    // Runtime rewrite of the flash lives with the flash controller.
    s_d.fetch_ext = fetch_req && s_q.ext_mode;
    s_d.fetch_nop = fetch_req && !s_q.ext_mode && (fetch_addr >= NOP_BASE);

    // A 16-bit increment carries on into the page byte.
    if (data_pointer_inc)
      {s_d.data_ptr_page, s_d.data_ptr_high, s_d.data_ptr_low} = data_pointer + 24'h000001;

    // SFR read mux; holes and the data flash window read zero.
    if (sfr_addr == SFR_SP)
      sfr_old = s_q.sp[7:0];
    else if (sfr_addr == SFR_SPH)
      sfr_old = {5'h00, s_q.sp[10:8]};
    else if (sfr_addr == SFR_PSW)
      sfr_old = s_q.processor_status_word;
    else if (sfr_addr == SFR_CFG)
      sfr_old = s_q.cfg;
    else if (sfr_addr == SFR_DPL)
      sfr_old = s_q.data_ptr_low;
    else if (sfr_addr == SFR_DPH)
      sfr_old = s_q.data_ptr_high;
    else if (sfr_addr == SFR_DPP)
      sfr_old = s_q.data_ptr_page;
    else
      sfr_old = 8'h00;
    if (req_kind == K_BIT)
    begin
      sfr_new = sfr_old;
      sfr_new[req_addr[2:0]] = req_wdata[0];
    end

    case (s_q.st)
      ST_IDLE:
      begin
        if (req_valid)
        begin
          s_d.kind   = req_kind;
          s_d.we     = req_we || (req_kind == K_PUSH);
          s_d.bitpos = req_addr[2:0];
          s_d.wdata  = req_wdata;
          s_d.onchip_extended_ram   = 1'b0;
          s_d.st     = ST_ISSUE;
          s_d.maddr  = {3'b000, req_addr};
          if ((req_kind == K_DIRECT || req_kind == K_BIT) && req_addr[7])
          begin
            // Upper direct addresses are SFRs, answered in one cycle.
            s_d.st    = ST_IDLE;
            s_d.done  = 1'b1;
            s_d.rdata = (req_kind == K_BIT) ? {7'h00, sfr_old[req_addr[2:0]]} : sfr_old;
            if (req_we)
            begin
              if (sfr_addr == SFR_SP)
                s_d.sp[7:0] = sfr_new;
              else if (sfr_addr == SFR_SPH)
              begin
                if (s_q.cfg[CFG_EXSP])
                  s_d.sp[10:8] = sfr_new[2:0] & SPH_IMPL_MASK;
              end
              else if (sfr_addr == SFR_PSW)
                s_d.processor_status_word[7:1] = sfr_new[7:1];
              else if (sfr_addr == SFR_CFG)
                s_d.cfg = sfr_new & CFG_IMPL_MASK;
              else if (sfr_addr == SFR_DPL)
                s_d.data_ptr_low = sfr_new;
              else if (sfr_addr == SFR_DPH)
                s_d.data_ptr_high = sfr_new;
              else if (sfr_addr == SFR_DPP)
                s_d.data_ptr_page = sfr_new;
            end
          end
          else if (req_kind == K_REG)
            s_d.maddr = {6'h00, s_q.processor_status_word[PSW_RS1:PSW_RS0], req_addr[2:0]};
          else if (req_kind == K_BIT)
            s_d.maddr = BIT_AREA_BASE + {7'h00, req_addr[6:3]};
          else if (req_kind == K_XDATA)
          begin
            if (s_q.cfg[CFG_ONCHIP_EXTENDED_RAM] && (data_pointer <= ONCHIP_EXTENDED_RAM_TOP))
            begin
              s_d.onchip_extended_ram  = 1'b1;
              s_d.maddr = data_pointer[10:0];
            end
            else
            begin
              // Strobes and pins come out only for external memory.
              s_d.st     = ST_EXT;
              s_d.cnt    = STROBE_LAST;
              s_d.xaddr  = data_pointer;
              s_d.rd_n   = req_we;
              s_d.wr_n   = !req_we;
              s_d.p2_out = data_pointer[15:8];
              s_d.p2_oe  = 1'b1;
              s_d.p0_out = req_wdata;
              s_d.p0_oe  = req_we;
            end
          end
          else if (req_kind == K_PUSH || req_kind == K_POP)
          begin
            // Without extension the pointer stays eight bits and wraps.
            if (req_kind == K_PUSH)
              sp_n = s_q.cfg[CFG_EXSP] ? s_q.sp + 11'h001
                                       : {3'b000, s_q.sp[7:0] + 8'h01};
            else
              sp_n = s_q.cfg[CFG_EXSP] ? s_q.sp - 11'h001
                                       : {3'b000, s_q.sp[7:0] - 8'h01};
            s_d.maddr = (req_kind == K_PUSH) ? sp_n : s_q.sp;
            s_d.onchip_extended_ram  = s_q.cfg[CFG_EXSP] && (s_d.maddr >= STACK_ONCHIP_EXTENDED_RAM_BASE);
            s_d.sp    = sp_n;
          end
        end
      end
      ST_ISSUE:
        s_d.st = ST_WAIT;
      ST_WAIT:
      begin
        s_d.st    = ST_IDLE;
        s_d.done  = 1'b1;
        s_d.rdata = (s_q.kind == K_BIT) ? {7'h00, ram_rd[s_q.bitpos]} : ram_rd;
      end
      ST_EXT:
      begin
        if (s_q.cnt == 3'h0)
        begin
          s_d.st    = ST_IDLE;
          s_d.done  = 1'b1;
          s_d.rdata = s_q.we ? 8'h00 : p0_sync;
          s_d.rd_n  = 1'b1;
          s_d.wr_n  = 1'b1;
          s_d.p0_oe = 1'b0;
          s_d.p2_oe = 1'b0;
        end
        else
          s_d.cnt = s_q.cnt - 3'h1;
      end
      default:
        s_d.st = ST_IDLE;
    endcase

    // With extension off the high stack bits are held at zero.
    if (!s_d.cfg[CFG_EXSP])
      s_d.sp[10:8] = 3'b000;
    s_d.busy = (s_d.st != ST_IDLE);
  end

  // Reset puts the status word, stack and configuration at their defaults.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= S_RESET;
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state flops.

  assign busy_q               = s_q.busy;
  assign done_q               = s_q.done;
  assign rdata_q              = s_q.rdata;
  assign ext_mode_q           = s_q.ext_mode;
  assign fetch_nop_q          = s_q.fetch_nop;
  assign fetch_ext_q          = s_q.fetch_ext;
  assign psw_q                = s_q.processor_status_word;
  assign sp_q                 = s_q.sp;
  assign data_pointer_q       = data_pointer;
  assign xaddr_q              = s_q.xaddr;
  assign rd_n_q               = s_q.rd_n;
  assign wr_n_q               = s_q.wr_n;
  assign port_zero_pins_out_q = s_q.p0_out;
  assign port_zero_pins_oe_q  = s_q.p0_oe;
  assign port_two_pins_out_q  = s_q.p2_out;
  assign port_two_pins_oe_q   = s_q.p2_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and cover points.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_code_src_hold: assert property (s_q.boot_cnt == BOOT_SYNC_CYC |=> $stable(s_q.ext_mode))
    else $error("code source changed after latch");
  a_top_fetch_nop: assert property (fetch_req && !s_q.ext_mode && fetch_addr >= NOP_BASE
    |=> s_q.fetch_nop)
    else $error("top region fetch not NOP");
  a_direct_sfr_hit: assert property (taken && req_kind == K_DIRECT && req_addr[7]
    |=> s_q.done && s_q.st == ST_IDLE)
    else $error("upper direct address reached RAM");
  a_bank_reg_map: assert property (taken && req_kind == K_REG |=> s_q.maddr ==
    {6'h00, $past(s_q.processor_status_word[PSW_RS1:PSW_RS0]), $past(req_addr[2:0])})
    else $error("register bank address wrong");
  a_bit_area_byte: assert property (taken && req_kind == K_BIT && !req_addr[7]
    |=> s_q.maddr == BIT_AREA_BASE + {7'h00, $past(req_addr[6:3])})
    else $error("bit address maps to wrong byte");
  a_push_pre_inc: assert property (taken && req_kind == K_PUSH && !s_q.cfg[CFG_EXSP]
    |=> s_q.sp == {3'b000, $past(s_q.sp[7:0]) + 8'h01} && s_q.maddr == s_q.sp)
    else $error("push did not pre-increment");
  a_onchip_extended_ram_limit_ext: assert property (taken && req_kind == K_XDATA && data_pointer > ONCHIP_EXTENDED_RAM_TOP
    |=> s_q.st == ST_EXT)
    else $error("high pointer did not go external");
  a_onchip_extended_ram_pins_idle: assert property (s_q.st == ST_ISSUE && s_q.onchip_extended_ram
    |-> s_q.rd_n && s_q.wr_n && !s_q.p0_oe && !s_q.p2_oe)
    else $error("pins driven during extended RAM access");
  a_sph_off_zero: assert property (!s_q.cfg[CFG_EXSP] |-> s_q.sp[10:8] == 3'b000)
    else $error("high stack bits set while extension off");
  a_ext_strobe_len: assert property ($fell(s_q.rd_n) |-> !s_q.rd_n [*4] ##1 s_q.rd_n)
    else $error("external read strobe width wrong");
  a_data_pointer_carry_page: assert property (data_pointer_inc && !taken |=> data_pointer == $past(data_pointer) + 24'h000001)
    else $error("data pointer increment wrong");
  a_parity_track: assert property ($past(rst_n) |-> s_q.processor_status_word[PSW_P] == ^$past(acc_value))
    else $error("parity flag does not match accumulator");

  c_push_into_onchip_extended_ram: cover property (taken && req_kind == K_PUSH ##1 s_q.onchip_extended_ram);
  c_bit_area_write: cover property (taken && req_kind == K_BIT && req_we && !req_addr[7]);
  c_ext_data_read: cover property (s_q.st == ST_EXT && !s_q.we ##[1:8] s_q.done);
endmodule : mmd_core_map
`default_nettype wire

// ===== design/mmd_pkg.sv
// Constants and types shared by the core memory-map decode block.
package mmd_pkg;

  // Core clock rate and the external data strobe width.
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned EXT_STROBE_NS  = 40;
  localparam int unsigned EXT_STROBE_CYC = (EXT_STROBE_NS * CLK_MHZ + 999) / 1000;

  // Memory widths.
  localparam int unsigned IRAM_AW = 8;
  localparam int unsigned ONCHIP_EXTENDED_RAM_AW = 11;

  // Special function register byte addresses.
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] SFR_SP   = 8'h81;
  localparam logic [7:0] SFR_DPL  = 8'h82;
  localparam logic [7:0] SFR_DPH  = 8'h83;
  localparam logic [7:0] SFR_DPP  = 8'h84;
  localparam logic [7:0] SFR_CFG  = 8'hAF;
  localparam logic [7:0] SFR_SPH  = 8'hB7;
  localparam logic [7:0] SFR_PSW  = 8'hD0;

  // Reset values.
  localparam logic [10:0] SP_RESET  = 11'h007;
  localparam logic [7:0]  PSW_RESET = 8'h00;
  localparam logic [7:0]  CFG_RESET = 8'h00;

  // Field positions and masks.
  localparam int unsigned PSW_RS1  = 4;
  localparam int unsigned PSW_RS0  = 3;
  localparam int unsigned PSW_P    = 0;
  localparam int unsigned CFG_ONCHIP_EXTENDED_RAM = 0;
  localparam int unsigned CFG_EXSP = 7;
  localparam logic [7:0]  CFG_IMPL_MASK = 8'h81;
  localparam logic [2:0]  SPH_IMPL_MASK = 3'h7;

  // Address map boundaries.
  localparam logic [15:0] NOP_BASE        = 16'hF800;
  localparam logic [10:0] BIT_AREA_BASE   = 11'h020;
  localparam logic [23:0] ONCHIP_EXTENDED_RAM_TOP        = 24'h0007FF;
  localparam logic [10:0] STACK_ONCHIP_EXTENDED_RAM_BASE = 11'h100;
  // Both sync stages reset low, so the pin level is only final three edges after release.
  localparam logic [1:0]  BOOT_SYNC_CYC   = 2'h3;

  // Kinds of data access requested by the core.
  typedef enum logic [2:0] {
    K_DIRECT   = 3'h0,
    K_INDIRECT = 3'h1,
    K_REG      = 3'h2,
    K_BIT      = 3'h3,
    K_XDATA    = 3'h4,
    K_PUSH     = 3'h5,
    K_POP      = 3'h6
  } mmd_kind_t;

  // Access sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ISSUE = 4'b0010,
    ST_WAIT  = 4'b0100,
    ST_EXT   = 4'b1000
  } mmd_state_t;

endpackage : mmd_pkg

// ===== design/mmd_ram_if.sv
// Interface carrying one byte-wide RAM port between decode and memory.
`timescale 1ns/1ps
`default_nettype none
interface mmd_ram_if #(parameter int unsigned AW = 8) ();
  logic          en;    // Access strobe.
  logic          we;    // Write when high, read when low.
  logic [AW-1:0] addr;  // Byte address.
  logic [7:0]    wdata; // Write data.
  logic [7:0]    rdata; // Registered read data.
  modport ctrl (output en, output we, output addr, output wdata, input rdata);
  modport mem  (input en, input we, input addr, input wdata, output rdata);
endinterface : mmd_ram_if
`default_nettype wire

// ===== design/mmd_sync.sv
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module mmd_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // Both stages live in one packed state word.
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mmd_sync_st_t;

  mmd_sync_st_t s_q;
  mmd_sync_st_t s_d;

  // The first stage feeds only the second stage.
  always_comb
  begin
    s_d    = s_q;
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign q = s_q.s2;
endmodule : mmd_sync
`default_nettype wire

// ===== design/mmd_ram.sv
// Byte-wide synchronous RAM with a registered read port.
`timescale 1ns/1ps
`default_nettype none
module mmd_ram #(
  parameter int unsigned AW = 8
) (
  input  wire logic clk,
  input  wire logic rst_n,
  mmd_ram_if.mem    bus
);
  logic [7:0] mem_q [0:(1<<AW)-1]; // Storage, not reset.
  logic [7:0] rd_q;                // Read data, held until the next read.

  // Writes land in the array; the array itself needs no reset.
  always_ff @(posedge clk)
  begin
    if (bus.en && bus.we)
      mem_q[bus.addr] <= bus.wdata;
  end

  // Read data stays put between reads so a later cycle can still use it.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_q <= 8'h00;
    else if (bus.en && !bus.we)
      rd_q <= mem_q[bus.addr];
  end

  assign bus.rdata = rd_q;
endmodule : mmd_ram
`default_nettype wire

// ===== verification/mmd_ext_mem_model.sv
// Far-side model: external data memory on the multiplexed port bus.
`timescale 1ns/1ps
`default_nettype none
module mmd_ext_mem_model (
  input  wire logic        clk,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [23:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        p0_oe,
  input  wire logic        p2_oe,
  output logic      [7:0]  rdata,
  output int               act
);
  logic [7:0] mem [256]; // Only the low address byte is decoded, to keep it small.
  initial act = 0;
  // Store write data while the store strobe and port drive are both active.
  always @(posedge clk)
  begin
    if (!wr_n && p0_oe)
      mem[addr[7:0]] <= wdata;
    if (!rd_n || !wr_n || p0_oe || p2_oe)
      act <= act + 1; // Any bus activity is counted so quiet spans can be checked.
  end
  // A released port floats to the pull-up level, never to the last value.
  assign rdata = rd_n ? 8'hFF : mem[addr[7:0]];
endmodule : mmd_ext_mem_model
`default_nettype wire

// ===== verification/core_memory_map_decode_tb_top.sv
// Testbench for the core memory-map decode block.
`timescale 1ns/1ps
`default_nettype none
module core_memory_map_decode_tb_top;
  import mmd_pkg::*;
  logic clk = 1'b0, rst_n, csel_n, fetch_req, req_valid, req_we, data_pointer_inc;
  logic [7:0] acc_value, req_addr, req_wdata, p0_in, rd, p0_out, p2_out;
  logic [15:0] fetch_addr;
  mmd_kind_t req_kind;
  logic busy, done, extm, fnop, fext, rdn, wrn, p0oe, p2oe;
  logic [7:0] processor_status_word;
  logic [10:0] sp;
  logic [23:0] data_pointer, xaddr;
  int error_cnt = 0, tests_run = 0, act, a0;
  always #5 clk = ~clk;
  mmd_core_map #(.STROBE_CYC(4)) DUT (.clk(clk), .rst_n(rst_n),
    .code_source_select_n(csel_n), .acc_value(acc_value), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .req_valid(req_valid), .req_kind(req_kind), .req_we(req_we),
    .req_addr(req_addr), .req_wdata(req_wdata), .data_pointer_inc(data_pointer_inc),
    .port_zero_pins_in(p0_in), .busy_q(busy), .done_q(done), .rdata_q(rd),
    .ext_mode_q(extm), .fetch_nop_q(fnop), .fetch_ext_q(fext), .psw_q(processor_status_word), .sp_q(sp),
    .data_pointer_q(data_pointer), .xaddr_q(xaddr), .rd_n_q(rdn), .wr_n_q(wrn),
    .port_zero_pins_out_q(p0_out), .port_zero_pins_oe_q(p0oe),
    .port_two_pins_out_q(p2_out), .port_two_pins_oe_q(p2oe));
  mmd_ext_mem_model mem (.clk(clk), .rd_n(rdn), .wr_n(wrn), .addr(xaddr), .wdata(p0_out),
    .p0_oe(p0oe), .p2_oe(p2oe), .rdata(p0_in), .act(act));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare one value and count it.
  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    tests_run++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One data access; the request is held until the take edge, then done is awaited.
  task automatic xs(input mmd_kind_t k, input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_we <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    chk("busy", busy, {23'h0, !((k == K_DIRECT || k == K_BIT) && a[7])});
    for (n = 0; n < 20 && done !== 1'b1; n++)
    begin
      @(posedge clk);
      #1;
    end
    if (n == 20)
      chk("done", 24'h0, 24'h1);
  endtask : xs
  // One fetch; the NOP flag is looked at in the cycle after the take edge.
  task automatic fet(input logic [15:0] a, input logic e);
    @(posedge clk);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    @(posedge clk);
    fetch_req <= 1'b0;
    #1;
    chk("nop", {23'h0, fnop}, {23'h0, e});
  endtask : fet
  // Closing report, reached from the main sequence or the watchdog.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////////
  // The whole run is a few hundred cycles, so this limit is generous.
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
  // Main sequence.
  initial
  begin
    {rst_n, fetch_req, req_valid, req_we, data_pointer_inc, acc_value} = '0;
    {fetch_addr, req_addr, req_wdata} = '0;
    csel_n = 1'b1;
    req_kind = K_DIRECT;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("sp", sp, 24'h7);
    chk("psw", processor_status_word, 24'h0);
    chk("ext", extm, 24'h0);
    xs(K_DIRECT, 1'b0, SFR_SP, 8'h00);
    chk("sp_rd", rd, 24'h07);
    xs(K_DIRECT, 1'b0, SFR_CFG, 8'h00);
    chk("cfg", rd, 24'h00);
    fet(16'hF800, 1'b1);
    fet(16'hF7FF, 1'b0);
    // Bank 3 register 0 must land at byte 18H.
    xs(K_DIRECT, 1'b1, SFR_PSW, 8'h18);
    xs(K_REG, 1'b1, 8'h00, 8'hAB);
    xs(K_INDIRECT, 1'b0, 8'h18, 8'h00);
    chk("bank", rd, 24'hAB);
    @(posedge clk);
    acc_value <= 8'h01;
    xs(K_DIRECT, 1'b0, SFR_PSW, 8'h00);
    chk("psw_rd", rd, 24'h19);
    xs(K_DIRECT, 1'b1, SFR_PSW, 8'h00);
    // The same upper address reaches RAM indirectly and an SFR directly.
    xs(K_INDIRECT, 1'b1, 8'h90, 8'h66);
    xs(K_DIRECT, 1'b0, 8'h90, 8'h00);
    chk("sfr90", rd, 24'h00);
    xs(K_INDIRECT, 1'b0, 8'h90, 8'h00);
    chk("ram90", rd, 24'h66);
    xs(K_INDIRECT, 1'b1, 8'h21, 8'h00);
    xs(K_BIT, 1'b1, 8'h0F, 8'h01);
    xs(K_INDIRECT, 1'b0, 8'h21, 8'h00);
    chk("bit0F", rd, 24'h80);
    // The stack at 08H stays clear of the bank 3 registers used above.
    xs(K_PUSH, 1'b1, 8'h00, 8'h5A);
    chk("sp_push", sp, 24'h008);
    xs(K_INDIRECT, 1'b0, 8'h08, 8'h00);
    chk("stack08", rd, 24'h5A);
    xs(K_POP, 1'b0, 8'h00, 8'h00);
    chk("pop", {rd, 5'h0, sp}, {8'h5A, 16'h0007});
    xs(K_DIRECT, 1'b1, SFR_SP, 8'hFF);
    xs(K_PUSH, 1'b1, 8'h00, 8'h11);
    chk("wrap", sp, 24'h000);
    xs(K_DIRECT, 1'b1, SFR_CFG, 8'h81);
    xs(K_DIRECT, 1'b0, SFR_CFG, 8'h00);
    chk("cfg_rd", rd, 24'h81);
    xs(K_DIRECT, 1'b1, SFR_SP, 8'hFF);
    xs(K_PUSH, 1'b1, 8'h00, 8'h22);
    chk("sp_ext", sp, 24'h100);
    xs(K_DIRECT, 1'b0, SFR_SPH, 8'h00);
    chk("sph", rd, 24'h01);
    xs(K_POP, 1'b0, 8'h00, 8'h00);
    chk("pop_ext", {rd, 5'h0, sp}, {8'h22, 16'h00FF});
    xs(K_DIRECT, 1'b1, SFR_DPP, 8'h00);
    xs(K_DIRECT, 1'b1, SFR_DPH, 8'hFF);
    xs(K_DIRECT, 1'b1, SFR_DPL, 8'hFF);
    @(posedge clk);
    data_pointer_inc <= 1'b1;
    @(posedge clk);
    data_pointer_inc <= 1'b0;
    #1;
    chk("data_pointer", data_pointer, 24'h010000);
    // Map is on, but a pointer past 0007FFH must still go out.
    xs(K_XDATA, 1'b1, 8'h00, 8'h3C);
    chk("xaddr", xaddr, 24'h010000);
    xs(K_XDATA, 1'b0, 8'h00, 8'h00);
    chk("xrd", rd, 24'h3C);
    chk("rel", {p2_out, 12'h0, p0oe, p2oe, rdn, wrn}, {8'h00, 16'h0003});
    xs(K_DIRECT, 1'b1, SFR_DPP, 8'h00);
    xs(K_DIRECT, 1'b1, SFR_DPH, 8'h00);
    a0 = act;
    xs(K_XDATA, 1'b1, 8'h00, 8'h77);
    xs(K_XDATA, 1'b0, 8'h00, 8'h00);
    chk("onchip_extended_ram", rd, 24'h77);
    chk("quiet", 24'(act - a0), 24'h0);
    xs(K_DIRECT, 1'b1, SFR_CFG, 8'h00);
    a0 = act;
    xs(K_XDATA, 1'b1, 8'h00, 8'h99);
    xs(K_XDATA, 1'b0, 8'h00, 8'h00);
    chk("ext_off", {rd, 15'h0, act > a0}, {8'h99, 16'h0001});
    // A second reset with the pin low must bring up external code mode.
    @(posedge clk);
    rst_n <= 1'b0;
    csel_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("ext_low", {extm, sp}, {1'b1, 11'h007});
    fet(16'hF800, 1'b0);
    chk("fext", fext, 24'h1);
    end_sim();
  end
endmodule : core_memory_map_decode_tb_top
`default_nettype wire
